// ### design/itc_pkg.sv
/*
  Constants, register map and shared types of the input terminal conditioning block.
  Assumes a single 200 MHz clock and an AHB-Lite register bus with 32-bit data.
*/
package itc_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFS_VIRTUAL = 8'h00;
  localparam logic [7:0] OFS_SLOT1 = 8'h04;
  localparam logic [7:0] OFS_SLOT5 = 8'h14;
  localparam logic [7:0] OFS_ZERO_CLAMP = 8'h18;
  localparam logic [7:0] OFS_DEV_FORMAT = 8'h1c;
  localparam logic [7:0] OFS_PULSE_FILTER = 8'h20;
  localparam logic [7:0] OFS_SPD_SCALE = 8'h24;
  localparam logic [7:0] OFS_SPD_OFFSET = 8'h28;
  localparam logic [7:0] OFS_TRQ_SCALE = 8'h2c;
  localparam logic [7:0] OFS_TRQ_OFFSET = 8'h30;
  localparam logic [7:0] OFS_SPD_GAIN = 8'h34;
  localparam logic [7:0] OFS_TRQ_GAIN = 8'h38;
  localparam logic [7:0] OFS_SPD_SMOOTH = 8'h3c;
  localparam logic [7:0] OFS_TRQ_SMOOTH = 8'h40;
  localparam logic [7:0] OFS_TERM_ASSIGN = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam int REG_COUNT = 18;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [15:0] RST_PULSE_FILTER = 16'h0003;
  localparam logic [15:0] RST_SPD_SCALE = 16'h0032;
  localparam logic [15:0] RST_TRQ_SCALE = 16'h001e;
  localparam logic [15:0] RST_FINE_GAIN = 16'h2710;
  localparam logic [15:0] RST_SMOOTH = 16'h0032;
  localparam int ASSIGN_BCAST_LSB = 0;
  localparam int ASSIGN_DEVCLR_LSB = 4;
  localparam int STAT_BCAST_EN = 8;
  localparam int STAT_PULSE = 9;
  localparam int STAT_ZERO_HOLD = 10;

  // ****************************************
  // Function codes, modes and scaling
  // ****************************************
  localparam logic [6:0] FUNC_BCAST_CANCEL = 7'h4e;
  localparam int FUNC_COUNT = 79;
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_SPEED = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  localparam longint SCALE_MV_PER_UNIT = 100;
  localparam longint GAIN_ONE = 10000;
  localparam longint TORQUE_FULL = 1000;
  localparam int OFFSET_TRQ_MV_PER_UNIT = 10;
  localparam int SMOOTH_TICK_NS = 10000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SMOOTH_TICK_CYCLES = SMOOTH_TICK_NS / CLK_PERIOD_NS;
  localparam int FRAC_BITS = 8;

  // Filter corner frequency in hertz for each code
  function automatic int itc_filter_hz(input logic [3:0] code);
    int hz_table [16] = '{15000000, 7500000, 3750000, 1875000, 312500, 234400, 156300,
                          117200, 78100, 58600, 46900, 39100, 29300, 23400, 19500, 14600};
    return hz_table[code];
  endfunction

  // Captured address phase of one bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] index;
  } itc_bus_phase_type;

endpackage

// ### design/itc_input_conditioning.sv
/*
  Input terminal conditioning: virtual inputs, always-on slots, broadcast cancel,
  deviation clear format, command pulse filter and analog reference processing.
  Assumes all inputs synchronous to CLK and a single AHB-Lite master.
*/
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module itc_input_conditioning
  import itc_pkg::*;
#(
  parameter int CLK_HZ = 200000000,
  parameter int RATED_RPM = 3000,
  parameter logic [6:0] POS_OT_FUNC = 7'h00,
  parameter logic [6:0] NEG_OT_FUNC = 7'h00
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [7:0] EI_PHYS,
  output logic [7:0] EI_EFFECTIVE,
  output logic [FUNC_COUNT-1:0] FORCE_MASK,
  output logic [FUNC_COUNT-1:0] FORCE_LEVEL,
  input wire logic QUERY_VALID,
  input wire logic QUERY_BCAST,
  output logic QUERY_ACCEPT,
  output logic QUERY_DISCARD,
  output logic BCAST_ENABLED,
  output logic DEV_CLEAR_PULSE,
  output logic ZERO_SPEED_HOLD,
  input wire logic PULSE_IN,
  output logic PULSE_OUT,
  input wire logic [1:0] CTRL_MODE,
  input wire logic signed [15:0] SPEED_REF_MV,
  input wire logic signed [15:0] TORQUE_REF_MV,
  output logic signed [15:0] SPEED_CMD_RPM,
  output logic signed [15:0] TORQUE_CMD
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Writable bits of each register
  function automatic logic [15:0] reg_mask(input logic [7:0] ofs);
    logic [15:0] m;
    m = 16'hffff;
    if (ofs == OFS_VIRTUAL) m = 16'h00ff;
    else if (ofs >= OFS_SLOT1 && ofs <= OFS_SLOT5) m = 16'h007f;
    else if (ofs == OFS_ZERO_CLAMP) m = 16'h01ff;
    else if (ofs == OFS_DEV_FORMAT) m = 16'h0001;
    else if (ofs == OFS_PULSE_FILTER) m = 16'h000f;
    else if (ofs == OFS_TERM_ASSIGN) m = 16'h00ff;
    else if (ofs == OFS_STATUS) m = 16'h0000;
    return m;
  endfunction

  // Value of each register after reset
  function automatic logic [15:0] reg_reset(input logic [7:0] ofs);
    logic [15:0] v;
    v = 16'h0000;
    if (ofs == OFS_PULSE_FILTER) v = RST_PULSE_FILTER;
    else if (ofs == OFS_SPD_SCALE) v = RST_SPD_SCALE;
    else if (ofs == OFS_TRQ_SCALE) v = RST_TRQ_SCALE;
    else if (ofs == OFS_SPD_GAIN || ofs == OFS_TRQ_GAIN) v = RST_FINE_GAIN;
    else if (ofs == OFS_SPD_SMOOTH || ofs == OFS_TRQ_SMOOTH) v = RST_SMOOTH;
    return v;
  endfunction

  // Reference in mV times fine gain, over scale in 0.1 V per full value
  function automatic logic signed [15:0] ref_to_cmd(input logic signed [17:0] mv,
                                                    input logic signed [15:0] scale,
                                                    input logic [15:0] gain,
                                                    input longint full);
    longint num;
    longint den;
    longint q;
    num = longint'(mv) * longint'(gain) * full;
    den = longint'(scale) * SCALE_MV_PER_UNIT * GAIN_ONE;
    q = (den == 0) ? 0 : num / den;
    if (q > 32767) q = 32767;
    if (q < -32768) q = -32768;
    return 16'(q);
  endfunction

  // First-order smoothing step, tau in 0.01 ms ticks; zero passes through
  function automatic logic signed [23:0] smooth_step(input logic signed [23:0] y,
                                                     input logic signed [15:0] x,
                                                     input logic [15:0] tau);
    logic signed [23:0] xf;
    logic signed [24:0] diff;
    xf = {x, 8'h00};
    diff = 25'(xf) - 25'(y);
    if (tau == 16'h0000) return xf;
    return y + 24'(diff / $signed({9'h000, tau}));
  endfunction

  // Stable time needed by the pulse filter, half a period rounded up
  function automatic logic [15:0] filter_cycles(input logic [3:0] code);
    longint twice;
    twice = 2 * longint'(itc_filter_hz(code));
    return 16'((longint'(CLK_HZ) + twice - 1) / twice);
  endfunction

  // ****************************************
  // Bus slave and register file
  // ****************************************
  logic [15:0] cfg_reg [REG_COUNT];
  logic [15:0] cfg_next [REG_COUNT];
  itc_bus_phase_type phase_reg;
  itc_bus_phase_type phase_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [15:0] status_word;
  logic [7:0] addr_ofs;
  logic [7:0] data_ofs;

  assign addr_ofs = {1'b0, HADDR[6:2], 2'b00};
  assign data_ofs = {1'b0, phase_reg.index, 2'b00};

  // Address phase capture, data phase write, early read data
  always_comb
  begin
    phase_next.valid = HSEL && HTRANS[1] && HREADY;
    phase_next.write = HWRITE && HADDR[31:7] == 25'h0;
    phase_next.index = HADDR[6:2];
    hrdata_next = hrdata_reg;
    for (int i = 0; i < REG_COUNT; i++)
    begin
      cfg_next[i] = cfg_reg[i];
    end
    if (phase_reg.valid && phase_reg.write && phase_reg.index < 5'(REG_COUNT))
    begin
      cfg_next[phase_reg.index] = HWDATA[15:0] & reg_mask(data_ofs);
    end
    if (phase_next.valid && !HWRITE)
    begin
      hrdata_next = 32'h00000000;
      if (HADDR[31:7] == 25'h0000000 && addr_ofs == OFS_STATUS)
        hrdata_next = {16'h0000, status_word};
      else if (HADDR[31:7] == 25'h0000000 && HADDR[6:2] < 5'(REG_COUNT))
        hrdata_next = {16'h0000, cfg_reg[HADDR[6:2]]};
    end
  end

  // Bus registers; zero wait states, always OKAY
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      phase_reg <= '0;
      hrdata_reg <= 32'h00000000;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        cfg_reg[i] <= reg_reset(8'(i * 4));
      end
    end
    else
    begin
      phase_reg <= phase_next;
      hrdata_reg <= hrdata_next;
      cfg_reg <= cfg_next;
    end
  end

  // ****************************************
  // Terminals, always-on slots, broadcast
  // ****************************************
  logic [7:0] virt_word;
  logic [3:0] bcast_sel;
  logic [3:0] devclr_sel;
  logic [7:0] ei_eff_reg;
  logic [7:0] ei_eff_next;
  logic [FUNC_COUNT-1:0] fmask_reg;
  logic [FUNC_COUNT-1:0] fmask_next;
  logic [FUNC_COUNT-1:0] flevel_reg;
  logic [FUNC_COUNT-1:0] flevel_next;
  logic bcast_en_reg;
  logic bcast_en_next;
  logic accept_reg;
  logic accept_next;
  logic discard_reg;
  logic discard_next;
  logic bcast_term_on;
  logic bcast_forced;

  assign virt_word = cfg_reg[OFS_VIRTUAL[6:2]][7:0];
  assign bcast_sel = cfg_reg[OFS_TERM_ASSIGN[6:2]][ASSIGN_BCAST_LSB +: 4];
  assign devclr_sel = cfg_reg[OFS_TERM_ASSIGN[6:2]][ASSIGN_DEVCLR_LSB +: 4];

  // Effective inputs, forced functions and query gating
  always_comb
  begin
    ei_eff_next = EI_PHYS | virt_word;
    fmask_next = '0;
    flevel_next = '0;
    bcast_forced = 1'b0;
    for (int s = 0; s < 5; s++)
    begin
      logic [6:0] code;
      code = cfg_reg[OFS_SLOT1[6:2] + 5'(s)][6:0];
      if (code != 7'h00 && code < 7'(FUNC_COUNT))
      begin
        fmask_next[code] = 1'b1;
        flevel_next[code] = !(code == POS_OT_FUNC || code == NEG_OT_FUNC);
      end
      if (code == FUNC_BCAST_CANCEL)
        bcast_forced = 1'b1;
    end
    // Unassigned terminal reads as off
    bcast_term_on = (bcast_sel != 4'h0 && bcast_sel <= 4'h8) &&
                    ei_eff_next[3'(bcast_sel - 4'h1)];
    bcast_en_next = !(bcast_term_on || bcast_forced);
    accept_next = QUERY_VALID && (!QUERY_BCAST || bcast_en_next);
    discard_next = QUERY_VALID && QUERY_BCAST && !bcast_en_next;
  end

  // Terminal and query registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ei_eff_reg <= 8'h00;
      fmask_reg <= '0;
      flevel_reg <= '0;
      bcast_en_reg <= 1'b1;
      accept_reg <= 1'b0;
      discard_reg <= 1'b0;
    end
    else
    begin
      ei_eff_reg <= ei_eff_next;
      fmask_reg <= fmask_next;
      flevel_reg <= flevel_next;
      bcast_en_reg <= bcast_en_next;
      accept_reg <= accept_next;
      discard_reg <= discard_next;
    end
  end

  // ****************************************
  // Deviation clear and pulse filter
  // ****************************************
  logic dev_prev_reg;
  logic dev_prev_next;
  logic dev_pulse_reg;
  logic dev_pulse_next;
  logic zero_hold_reg;
  logic zero_hold_next;
  logic pulse_out_reg;
  logic pulse_out_next;
  logic [15:0] stable_cnt_reg;
  logic [15:0] stable_cnt_next;
  logic dev_on;
  logic dev_level_fmt;

  assign dev_level_fmt = cfg_reg[OFS_DEV_FORMAT[6:2]][0];
  assign dev_on = (devclr_sel != 4'h0 && devclr_sel <= 4'h8) &&
                  ei_eff_reg[3'(devclr_sel - 4'h1)];

  // Edge or level clear, and a stable-time filter on the command pulse
  always_comb
  begin
    dev_prev_next = dev_on;
    dev_pulse_next = !dev_level_fmt && dev_on && !dev_prev_reg;
    zero_hold_next = dev_level_fmt && dev_on;
    pulse_out_next = pulse_out_reg;
    stable_cnt_next = 16'h0000;
    if (PULSE_IN != pulse_out_reg)
    begin
      stable_cnt_next = stable_cnt_reg + 16'h0001;
      if (stable_cnt_next >= filter_cycles(cfg_reg[OFS_PULSE_FILTER[6:2]][3:0]))
      begin
        pulse_out_next = PULSE_IN;
        stable_cnt_next = 16'h0000;
      end
    end
  end

  // Deviation clear and filter registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      dev_prev_reg <= 1'b0;
      dev_pulse_reg <= 1'b0;
      zero_hold_reg <= 1'b0;
      pulse_out_reg <= 1'b0;
      stable_cnt_reg <= 16'h0000;
    end
    else
    begin
      dev_prev_reg <= dev_prev_next;
      dev_pulse_reg <= dev_pulse_next;
      zero_hold_reg <= zero_hold_next;
      pulse_out_reg <= pulse_out_next;
      stable_cnt_reg <= stable_cnt_next;
    end
  end

  // ****************************************
  // Analog reference processing
  // ****************************************
  logic signed [23:0] spd_filt_reg;
  logic signed [23:0] spd_filt_next;
  logic signed [23:0] trq_filt_reg;
  logic signed [23:0] trq_filt_next;
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  logic signed [15:0] spd_cmd_reg;
  logic signed [15:0] spd_cmd_next;
  logic signed [15:0] trq_cmd_reg;
  logic signed [15:0] trq_cmd_next;
  logic signed [15:0] spd_bare;
  logic signed [17:0] spd_mv;
  logic signed [17:0] trq_mv;
  logic [15:0] spd_mag;

  // Smoothing on a 10 us tick, then offset, scale, gain and zero clamp
  always_comb
  begin
    tick_cnt_next = tick_cnt_reg + 16'h0001;
    spd_filt_next = spd_filt_reg;
    trq_filt_next = trq_filt_reg;
    if (tick_cnt_reg == 16'(SMOOTH_TICK_CYCLES - 1))
    begin
      tick_cnt_next = 16'h0000;
      spd_filt_next = smooth_step(spd_filt_reg, SPEED_REF_MV,
                                  cfg_reg[OFS_SPD_SMOOTH[6:2]]);
      trq_filt_next = smooth_step(trq_filt_reg, TORQUE_REF_MV,
                                  cfg_reg[OFS_TRQ_SMOOTH[6:2]]);
    end
    spd_mv = 18'(spd_filt_reg >>> FRAC_BITS) +
             18'($signed(cfg_reg[OFS_SPD_OFFSET[6:2]]));
    trq_mv = 18'(trq_filt_reg >>> FRAC_BITS) +
             18'($signed(cfg_reg[OFS_TRQ_OFFSET[6:2]]) * OFFSET_TRQ_MV_PER_UNIT);
    // Clamp decision uses the command without offset correction
    spd_bare = ref_to_cmd(18'(spd_filt_reg >>> FRAC_BITS), cfg_reg[OFS_SPD_SCALE[6:2]],
                          cfg_reg[OFS_SPD_GAIN[6:2]], longint'(RATED_RPM));
    spd_mag = spd_bare[15] ? 16'(-spd_bare) : spd_bare;
    spd_cmd_next = ref_to_cmd(spd_mv, cfg_reg[OFS_SPD_SCALE[6:2]],
                              cfg_reg[OFS_SPD_GAIN[6:2]], longint'(RATED_RPM));
    if (CTRL_MODE != MODE_TORQUE && spd_mag < cfg_reg[OFS_ZERO_CLAMP[6:2]])
      spd_cmd_next = 16'h0000;
    trq_cmd_next = ref_to_cmd(trq_mv, cfg_reg[OFS_TRQ_SCALE[6:2]],
                              cfg_reg[OFS_TRQ_GAIN[6:2]], TORQUE_FULL);
  end

  // Reference registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      spd_filt_reg <= 24'h000000;
      trq_filt_reg <= 24'h000000;
      tick_cnt_reg <= 16'h0000;
      spd_cmd_reg <= 16'h0000;
      trq_cmd_reg <= 16'h0000;
    end
    else
    begin
      spd_filt_reg <= spd_filt_next;
      trq_filt_reg <= trq_filt_next;
      tick_cnt_reg <= tick_cnt_next;
      spd_cmd_reg <= spd_cmd_next;
      trq_cmd_reg <= trq_cmd_next;
    end
  end

  // ****************************************
  // Status and outputs
  // ****************************************
  assign status_word = {5'h00, zero_hold_reg, pulse_out_reg, bcast_en_reg, ei_eff_reg};
  assign HRDATA = hrdata_reg;
  assign HREADYOUT = !RESET || 1'b1;
  assign HRESP = 1'b0;
  assign EI_EFFECTIVE = ei_eff_reg;
  assign FORCE_MASK = fmask_reg;
  assign FORCE_LEVEL = flevel_reg;
  assign QUERY_ACCEPT = accept_reg;
  assign QUERY_DISCARD = discard_reg;
  assign BCAST_ENABLED = bcast_en_reg;
  assign DEV_CLEAR_PULSE = dev_pulse_reg;
  assign ZERO_SPEED_HOLD = zero_hold_reg;
  assign PULSE_OUT = pulse_out_reg;
  assign SPEED_CMD_RPM = spd_cmd_reg;
  assign TORQUE_CMD = trq_cmd_reg;

endmodule

// ### bench/itc_monitor.sv
/*
  Port checker of the input conditioning block.
  Assumes it is bound to the block's top module.
*/
`timescale 1ns/10ps
module itc_monitor
  import itc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] EI_PHYS,
  input wire logic [7:0] EI_EFFECTIVE,
  input wire logic [FUNC_COUNT-1:0] FORCE_MASK,
  input wire logic QUERY_VALID,
  input wire logic QUERY_BCAST,
  input wire logic QUERY_ACCEPT,
  input wire logic QUERY_DISCARD,
  input wire logic BCAST_ENABLED,
  input wire logic DEV_CLEAR_PULSE,
  input wire logic ZERO_SPEED_HOLD,
  input wire logic PULSE_IN,
  input wire logic PULSE_OUT
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // Query answers
  a_query_answered: assert property (QUERY_VALID |=> QUERY_ACCEPT ^ QUERY_DISCARD)
    else $error("query not answered once");
  a_no_stray: assert property (!QUERY_VALID |=> !QUERY_ACCEPT && !QUERY_DISCARD)
    else $error("answer without query");
  a_unicast_taken: assert property (QUERY_VALID && !QUERY_BCAST |=> QUERY_ACCEPT)
    else $error("unicast refused");
  a_discard_bcast: assert property (QUERY_DISCARD |-> $past(QUERY_BCAST))
    else $error("unicast discarded");
  // Broadcast cancel held by an always-on slot
  a_slot_cancels: assert property (FORCE_MASK[78] [*3] |-> !BCAST_ENABLED)
    else $error("broadcast on with slot cancel");
  a_slot_drops: assert property
    ((FORCE_MASK[78] [*3] ##0 (QUERY_VALID && QUERY_BCAST)) |=> QUERY_DISCARD)
    else $error("broadcast kept with slot cancel");
  // Terminals, deviation clear and pulse filter
  a_virtual_or: assert property
    (!$past(RESET) |-> (EI_EFFECTIVE & $past(EI_PHYS)) == $past(EI_PHYS))
    else $error("physical input lost");
  a_clear_single: assert property (DEV_CLEAR_PULSE |=> !DEV_CLEAR_PULSE)
    else $error("clear pulse too long");
  a_clear_modes: assert property (!(DEV_CLEAR_PULSE && ZERO_SPEED_HOLD))
    else $error("edge and level clear together");
  a_filter_hold: assert property
    ($changed(PULSE_OUT) |-> $past(PULSE_IN, 2) == PULSE_OUT && $past(PULSE_IN, 6) == PULSE_OUT)
    else $error("pulse passed too early");
  // Main scenarios reached
  c_discard: cover property (QUERY_DISCARD);
  c_pulse: cover property ($rose(PULSE_OUT));
  c_hold: cover property (ZERO_SPEED_HOLD);
endmodule

bind itc_input_conditioning itc_monitor u_itc_monitor (
  .CLK(CLK), .RESET(RESET), .EI_PHYS(EI_PHYS), .EI_EFFECTIVE(EI_EFFECTIVE),
  .FORCE_MASK(FORCE_MASK), .QUERY_VALID(QUERY_VALID), .QUERY_BCAST(QUERY_BCAST),
  .QUERY_ACCEPT(QUERY_ACCEPT), .QUERY_DISCARD(QUERY_DISCARD), .BCAST_ENABLED(BCAST_ENABLED),
  .DEV_CLEAR_PULSE(DEV_CLEAR_PULSE), .ZERO_SPEED_HOLD(ZERO_SPEED_HOLD), .PULSE_IN(PULSE_IN),
  .PULSE_OUT(PULSE_OUT)
);

// ### bench/itc_host_model.sv
/*
  Host controller model: terminals, queries and command pulses.
  Assumes its tasks are called from one bench process.
*/
`timescale 1ns/10ps
module itc_host_model
(
  input wire logic clk,
  output logic [7:0] ei_phys,
  output logic query_valid,
  output logic query_bcast,
  output logic pulse_in
);
  // ****************************************
  // Host drivers
  // ****************************************
  // Idle levels from time zero
  initial
  begin
    ei_phys = 8'h00;
    query_valid = 1'b0;
    query_bcast = 1'b0;
    pulse_in = 1'b0;
  end
  // Terminal levels change just after an edge
  task automatic set_terms(input logic [7:0] v);
    @(posedge clk);
    ei_phys <= v;
  endtask
  // One query cycle; the qualifier is inverted once released
  task automatic send_query(input logic b);
    @(posedge clk);
    query_valid <= 1'b1;
    query_bcast <= b;
    @(posedge clk);
    query_valid <= 1'b0;
    query_bcast <= !b;
  endtask
  // Raw command pulse level
  task automatic set_pulse(input logic l);
    @(posedge clk);
    pulse_in <= l;
  endtask
endmodule

// ### bench/itc_input_conditioning_tb_top.sv
/*
  Self-checking bench of the input conditioning block.
  Assumes the host model beside it and the bound port checker.
*/
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module itc_input_conditioning_tb_top
  import itc_pkg::*;
;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  localparam logic [6:0] OT = 7'h05;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic HWRITE = 1'b0;
  logic [1:0] CTRL_MODE = 2'h1;
  logic signed [15:0] SPEED_REF_MV = 16'sh0;
  logic signed [15:0] TORQUE_REF_MV = 16'sh0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, QUERY_VALID, QUERY_BCAST, QUERY_ACCEPT, QUERY_DISCARD;
  logic BCAST_ENABLED, DEV_CLEAR_PULSE, ZERO_SPEED_HOLD, PULSE_IN, PULSE_OUT;
  logic [7:0] EI_PHYS, EI_EFFECTIVE;
  logic [FUNC_COUNT-1:0] FORCE_MASK, FORCE_LEVEL;
  logic signed [15:0] SPEED_CMD_RPM, TORQUE_CMD;
  int error_cnt = 0;
  int checks_done = 0;
  // Free running clock
  initial
  begin
    forever #2.5 CLK = ~CLK;
  end
  itc_input_conditioning #(.POS_OT_FUNC(OT), .NEG_OT_FUNC(OT)) u_itc_input_conditioning (
    .CLK(CLK), .RESET(RESET), .HSEL(HTRANS[1]), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'(HTRANS)), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EI_PHYS(EI_PHYS), .EI_EFFECTIVE(EI_EFFECTIVE),
    .FORCE_MASK(FORCE_MASK), .FORCE_LEVEL(FORCE_LEVEL), .QUERY_VALID(QUERY_VALID),
    .QUERY_BCAST(QUERY_BCAST), .QUERY_ACCEPT(QUERY_ACCEPT), .QUERY_DISCARD(QUERY_DISCARD),
    .BCAST_ENABLED(BCAST_ENABLED), .DEV_CLEAR_PULSE(DEV_CLEAR_PULSE),
    .ZERO_SPEED_HOLD(ZERO_SPEED_HOLD), .PULSE_IN(PULSE_IN), .PULSE_OUT(PULSE_OUT),
    .CTRL_MODE(CTRL_MODE), .SPEED_REF_MV(SPEED_REF_MV), .TORQUE_REF_MV(TORQUE_REF_MV),
    .SPEED_CMD_RPM(SPEED_CMD_RPM), .TORQUE_CMD(TORQUE_CMD));
  itc_host_model u_itc_host_model (.clk(CLK), .ei_phys(EI_PHYS), .query_valid(QUERY_VALID),
    .query_bcast(QUERY_BCAST), .pulse_in(PULSE_IN));
  // ****************************************
  // Bus tasks and helpers
  // ****************************************
  // Verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Next edge with ready high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge CLK);
    end
    if (n >= 100)
    begin
      error_cnt++;
      end_sim();
    end
  endtask
  // One single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge CLK);
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    wait_ready();
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_ready();
    q = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK({HRESP, q}, {1'b0, e})
  endtask
  // Query and its answer as {accept, discard}
  task automatic q_chk(input logic b, input logic [1:0] e);
    u_itc_host_model.send_query(b);
    @(posedge CLK);
    `CHK({QUERY_ACCEPT, QUERY_DISCARD}, e)
  endtask
  // References applied, commands after a smoothing tick
  task automatic ref_chk(input int s, input int t, input int es, input int et);
    SPEED_REF_MV <= 16'(s);
    TORQUE_REF_MV <= 16'(t);
    repeat (2100) @(posedge CLK);
    `CHK(SPEED_CMD_RPM, 16'(es))
    `CHK(TORQUE_CMD, 16'(et))
  endtask
  // Pulse filter delay for a code of corner frequency f
  task automatic filt_chk(input logic [3:0] c, input int f, input logic l);
    int n;
    int ne;
    ne = (200000000 + 2 * f - 1) / (2 * f);
    wr(OFS_PULSE_FILTER, {28'h0, c});
    u_itc_host_model.set_pulse(l);
    n = 0;
    while (PULSE_OUT !== l && n < 300)
    begin
      @(posedge CLK);
      n++;
    end
    `CHK(n >= ne && n <= ne + 3, 1'b1)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values, widths and an unmapped word
  task automatic t_regs();
    logic [7:0] a [6] = '{OFS_VIRTUAL, OFS_SLOT1, OFS_SLOT5, OFS_ZERO_CLAMP, OFS_DEV_FORMAT,
                          OFS_PULSE_FILTER};
    logic [31:0] m [6] = '{32'hff, 32'h7f, 32'h7f, 32'h1ff, 32'h1, 32'hf};
    foreach (a[i])
    begin
      rd_chk(a[i], i == 5 ? 32'h3 : 32'h0);
      wr(a[i], 32'hffffffff);
      rd_chk(a[i], m[i]);
      wr(a[i], i == 5 ? 32'h3 : 32'h0);
    end
    wr(8'h84, 32'h4e);
    rd_chk(8'h84, 32'h0);
  endtask
  // Virtual word bit by bit, then ORed with terminals
  task automatic t_virtual();
    for (int k = 0; k < 8; k++)
    begin
      wr(OFS_VIRTUAL, 32'h1 << k);
      repeat (2) @(posedge CLK);
      `CHK(EI_EFFECTIVE, 8'h1 << k)
    end
    u_itc_host_model.set_terms(8'h5a);
    wr(OFS_VIRTUAL, 32'h81);
    repeat (2) @(posedge CLK);
    `CHK(EI_EFFECTIVE, 8'hdb)
    rd_chk(OFS_STATUS, 32'h1db);
    wr(OFS_VIRTUAL, 32'h0);
    u_itc_host_model.set_terms(8'h00);
  endtask
  // Broadcast gating by the cancel terminal
  task automatic t_bcast();
    q_chk(1'b1, 2'b10);
    wr(OFS_TERM_ASSIGN, 32'h3);
    q_chk(1'b1, 2'b10);
    u_itc_host_model.set_terms(8'h04);
    q_chk(1'b1, 2'b01);
    q_chk(1'b0, 2'b10);
    `CHK(BCAST_ENABLED, 1'b0)
    u_itc_host_model.set_terms(8'h00);
    wr(OFS_VIRTUAL, 32'h4);
    q_chk(1'b1, 2'b01);
    wr(OFS_VIRTUAL, 32'h0);
  endtask
  // Always-on slots with permitted codes only
  task automatic t_slots();
    wr(OFS_SLOT1, 32'd78);
    wr(OFS_SLOT1 + 8'h04, 32'd2);
    wr(OFS_SLOT1 + 8'h08, {25'h0, OT});
    repeat (2) @(posedge CLK);
    `CHK(BCAST_ENABLED, 1'b0)
    q_chk(1'b1, 2'b01);
    `CHK({FORCE_LEVEL[2], FORCE_MASK[2]}, 2'b11)
    `CHK({FORCE_LEVEL[OT], FORCE_MASK[OT]}, 2'b01)
    u_itc_host_model.set_terms(8'h04);
    q_chk(1'b1, 2'b01);
    u_itc_host_model.set_terms(8'h00);
    for (int s = 0; s < 3; s++)
    begin
      wr(OFS_SLOT1 + 8'(4 * s), 32'h0);
    end
    repeat (2) @(posedge CLK);
    `CHK({BCAST_ENABLED, FORCE_MASK[78]}, 2'b10)
  endtask
  // Edge and level deviation clear on terminal 4
  task automatic t_devclr();
    int n;
    wr(OFS_TERM_ASSIGN, 32'h40);
    for (int f = 0; f < 2; f++)
    begin
      wr(OFS_DEV_FORMAT, 32'(f));
      u_itc_host_model.set_terms(8'h08);
      n = 0;
      repeat (6)
      begin
        @(posedge CLK);
        n += int'(DEV_CLEAR_PULSE === 1'b1);
      end
      `CHK(n, 1 - f)
      `CHK(ZERO_SPEED_HOLD, 1'(f))
      u_itc_host_model.set_terms(8'h00);
      repeat (3) @(posedge CLK);
      `CHK(ZERO_SPEED_HOLD, 1'b0)
    end
    wr(OFS_DEV_FORMAT, 32'h0);
  endtask
  // Glitch rejected, then delays for codes 0 and 3
  task automatic t_filter();
    wr(OFS_PULSE_FILTER, 32'h0);
    u_itc_host_model.set_pulse(1'b1);
    repeat (2) @(posedge CLK);
    u_itc_host_model.set_pulse(1'b0);
    repeat (12) @(posedge CLK);
    `CHK(PULSE_OUT, 1'b0)
    filt_chk(4'h0, 15000000, 1'b1);
    filt_chk(4'h3, 1875000, 1'b0);
  endtask
  // Smoothing, scale, gain, offset and zero clamp
  task automatic t_refs();
    SPEED_REF_MV <= 16'sd5000;
    TORQUE_REF_MV <= 16'sd3000;
    repeat (2100) @(posedge CLK);
    `CHK(SPEED_CMD_RPM > 0 && SPEED_CMD_RPM < 3000, 1'b1)
    `CHK(TORQUE_CMD > 0 && TORQUE_CMD < 1000, 1'b1)
    wr(OFS_SPD_SMOOTH, 32'h0);
    wr(OFS_TRQ_SMOOTH, 32'h0);
    ref_chk(5000, 3000, 3000, 1000);
    wr(OFS_SPD_GAIN, 32'd10100);
    wr(OFS_TRQ_GAIN, 32'd10100);
    ref_chk(5000, 3000, 3030, 1010);
    wr(OFS_SPD_GAIN, 32'd10000);
    wr(OFS_TRQ_GAIN, 32'd10000);
    wr(OFS_SPD_OFFSET, 32'd100);
    ref_chk(5000, 0, 3060, 0);
    wr(OFS_ZERO_CLAMP, 32'd200);
    CTRL_MODE <= MODE_POSITION;
    ref_chk(300, 0, 0, 0);
    ref_chk(-300, 0, 0, 0);
    ref_chk(400, 0, 300, 0);
    CTRL_MODE <= MODE_TORQUE;
    ref_chk(300, 0, 240, 0);
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    t_regs();
    t_virtual();
    t_bcast();
    t_slots();
    t_devclr();
    t_filter();
    t_refs();
    end_sim();
  end
endmodule
